// File: verilog/vpd_params.svh
// Field positions and constants of the packet dispatch core
`ifndef VPD_PARAMS_SVH
`define VPD_PARAMS_SVH
`define VPD_SLOTS 8
`define VPD_PKT_BYTES 32'h0000_0020
`define VPD_PKT_END 4'h8
`define VPD_RESET_PC 32'h0000_0000
`define VPD_F_P 0
`define VPD_F_UNIT 3:1
`define VPD_F_FUNC 11:8
`define VPD_F_SIMD 7:6
`define VPD_F_X 12
`define VPD_F_SRC1 17:13
`define VPD_F_SRC2 22:18
`define VPD_F_DST 27:23
`define VPD_F_Z 28
`define VPD_F_CREG 31:29
`define VPD_F_CIRC 11
`define VPD_F_UNS 10
`define VPD_F_LONG 7
`define VPD_F_ST 6
`define VPD_F_SIZE 5:4
`define VPD_F_OFS15 22:8
`define VPD_CREG_ALWAYS 3'h0
`define VPD_CREG_NEVER 3'h7
`define VPD_OP_ADD 4'h0
`define VPD_OP_SUB 4'h1
`define VPD_OP_AND 4'h2
`define VPD_OP_OR 4'h3
`define VPD_OP_XOR 4'h4
`define VPD_OP_SHL 4'h5
`define VPD_OP_SHR 4'h6
`define VPD_OP_SHRU 4'h7
`define VPD_OP_BR 4'h8
`define VPD_M_MPY2 4'h0
`define VPD_M_MPY4 4'h1
`define VPD_M_MPY1632 4'h2
`define VPD_M_DOT2 4'h3
`define VPD_M_DOTN2 4'h4
`define VPD_M_DOT4 4'h5
`define VPD_M_BITC 4'h6
`define VPD_M_ROTL 4'h7
`define VPD_M_GMPY 4'h8
`define VPD_M_VSHL 4'h9
`define VPD_W16 2'h1
`define VPD_W8 2'h2
`define VPD_SZ_B 2'h0
`define VPD_SZ_H 2'h1
`define VPD_SZ_D 2'h3
`define VPD_LONG_BASE 5'h0E
`define VPD_CIRC_LOG2 10
`define VPD_GF_POLY 8'h1D
`define VPD_PRED_A0 6'h00
`define VPD_PRED_A1 6'h01
`define VPD_PRED_A2 6'h02
`define VPD_PRED_B0 6'h20
`define VPD_PRED_B1 6'h21
`define VPD_PRED_B2 6'h22
`endif

// File: verilog/vpd_pkg.sv
// Types of the packet dispatch core
package vpd_pkg;
	typedef enum logic [0:0] {ST_FETCH, ST_RUN} vpd_state_e;
	typedef logic [5:0] vpd_raddr_t;
endpackage

// File: verilog/vpd_regfile.sv
// Two 32 x 32-bit register files with pair access and write tracking
`timescale 1ns/1ps
`include "vpd_params.svh"
module vpd_regfile (
	input  wire logic                i_mclk,       // Core clock
	input  wire logic                i_reset_n,    // Async reset, low
	input  wire vpd_pkg::vpd_raddr_t i_raddr [16], // {side, index}
	output logic [63:0]              o_rdata [16], // {odd, addressed}
	input  wire logic                i_we    [8],  // Write strobe
	input  wire logic                i_wide  [8],  // Pair write
	input  wire vpd_pkg::vpd_raddr_t i_waddr [8],  // {side, index}
	input  wire logic [63:0]         i_wdata [8],  // Write data
	output logic [63:0]              o_wr_mask,    // Written last cycle
	output logic [7:0]               o_pred        // Nonzero by creg
);
	logic [31:0] regs_r [64];
	logic [63:0] wmask;

	// --------------------------------------------------------------
	// Write ports
	// --------------------------------------------------------------
	// Registers touched this cycle
	always_comb begin
		wmask = '0;
		for (int p = 0; p < 8; p++) begin
			if (i_we[p]) begin
				wmask[{i_waddr[p][5:1], i_waddr[p][0] & ~i_wide[p]}] = 1'b1;
				if (i_wide[p]) wmask[{i_waddr[p][5:1], 1'b1}] = 1'b1;
			end
		end
	end

	// Storage, wide values land low in even, high in odd
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < 64; i++) regs_r[i] <= '0;
		end else begin
			for (int p = 0; p < 8; p++) begin
				if (i_we[p]) begin
					regs_r[{i_waddr[p][5:1], i_waddr[p][0] & ~i_wide[p]}] <= i_wdata[p][31:0];
					if (i_wide[p]) regs_r[{i_waddr[p][5:1], 1'b1}] <= i_wdata[p][63:32];
				end
			end
		end
	end

	// Map of last cycle's writes for the cross-side check
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) o_wr_mask <= '0;
		else o_wr_mask <= wmask;
	end

	// --------------------------------------------------------------
	// Read ports, all served in the same cycle
	// --------------------------------------------------------------
	for (genvar r = 0; r < 16; r++) begin : g_rd
		assign o_rdata[r] = {regs_r[{i_raddr[r][5:1], 1'b1}], regs_r[i_raddr[r]]};
	end

	// Predicate flags, index 0 always true, 7 never
	assign o_pred = {1'b0, |regs_r[`VPD_PRED_A0], |regs_r[`VPD_PRED_A2],
		|regs_r[`VPD_PRED_A1], |regs_r[`VPD_PRED_B2], |regs_r[`VPD_PRED_B1],
		|regs_r[`VPD_PRED_B0], 1'b1};
endmodule

// File: verilog/vpd_mul_unit.sv
// Multiply unit datapath: packed multiplies and bit operations
`timescale 1ns/1ps
`include "vpd_params.svh"
module vpd_mul_unit (
	input  wire logic [3:0]  i_func, // Operation
	input  wire logic [31:0] i_a,    // First operand
	input  wire logic [31:0] i_b,    // Second operand
	output logic [63:0]      o_res,  // Result, pair when wide
	output logic             o_wide  // Result fills a pair
);
	logic signed [31:0] p0, p1;
	logic signed [47:0] p48;
	logic [15:0]        q [4];
	logic [31:0]        dot4, cnt, gfm;
	logic [63:0]        rot;
	logic [5:0]         nsh;

	// Galois multiply of two bytes over the field polynomial
	function automatic logic [7:0] gf_mul(input logic [7:0] x, input logic [7:0] y);
		logic [7:0] r;
		logic [7:0] t;
		r = 8'h00;
		t = x;
		for (int i = 0; i < 8; i++) begin
			if (y[i]) r = r ^ t;
			t = t[7] ? ({t[6:0], 1'b0} ^ `VPD_GF_POLY) : {t[6:0], 1'b0};
		end
		return r;
	endfunction

	// Partial products and per-byte results
	always_comb begin
		p0 = $signed(i_a[15:0]) * $signed(i_b[15:0]);
		p1 = $signed(i_a[31:16]) * $signed(i_b[31:16]);
		p48 = $signed(i_a[15:0]) * $signed(i_b);
		dot4 = '0;
		for (int k = 0; k < 4; k++) begin
			q[k] = i_a[8*k +: 8] * i_b[8*k +: 8];
			dot4 = dot4 + {16'h0000, q[k]};
			cnt[8*k +: 8] = 8'($countones(i_b[8*k +: 8]));
			gfm[8*k +: 8] = gf_mul(i_a[8*k +: 8], i_b[8*k +: 8]);
		end
		rot = {i_b, i_b} << i_a[4:0];
		nsh = 6'h00 - i_a[5:0];
	end

	// Result selection
	always_comb begin
		o_res = '0;
		o_wide = 1'b0;
		case (i_func)
			`VPD_M_MPY2:    begin o_res = {p1, p0}; o_wide = 1'b1; end
			`VPD_M_MPY4:    begin o_res = {q[3], q[2], q[1], q[0]}; o_wide = 1'b1; end
			`VPD_M_MPY1632: begin o_res = {{16{p48[47]}}, p48}; o_wide = 1'b1; end
			`VPD_M_DOT2:    o_res = {32'h0, 32'(p1 + p0)};
			`VPD_M_DOTN2:   o_res = {32'h0, 32'(p1 - p0)};
			`VPD_M_DOT4:    o_res = {32'h0, dot4};
			`VPD_M_BITC:    o_res = {32'h0, cnt};
			`VPD_M_ROTL:    o_res = {32'h0, rot[63:32]};
			`VPD_M_GMPY:    o_res = {32'h0, gfm};
			`VPD_M_VSHL:    o_res = i_a[5] ? {32'h0, 32'($signed(i_b) >>> nsh)}
				: {32'h0, 32'(i_b << i_a[5:0])};
			default:        o_res = '0;
		endcase
	end
endmodule

// File: verilog/vpd_dispatch_core.sv
// Fetch, execute-group formation and dispatch of the two-sided core
`timescale 1ns/1ps
`include "vpd_params.svh"
module vpd_dispatch_core (
	input  wire logic             i_mclk,        // Core clock
	input  wire logic             i_reset_n,     // Async reset, low
	output logic                  o_fetch_req,   // Packet wanted
	output logic [31:0]           o_fetch_addr,  // Packet byte address
	input  wire logic             i_fetch_valid, // Packet present
	input  wire logic [255:0]     i_fetch_data,  // Slot 0 in low bits
	output logic [1:0]            o_dmem_req,    // Access, [0] side a
	output logic [1:0]            o_dmem_we,     // Store
	output logic [1:0][1:0]       o_dmem_size,   // Byte to doubleword
	output logic [1:0][31:0]      o_dmem_addr,   // Any byte address
	output logic [1:0][63:0]      o_dmem_wdata,  // Store data
	input  wire logic [1:0][63:0] i_dmem_rdata,  // Load data, in the request cycle
	output logic [7:0]            o_issue_mask,  // Units issued
	output logic                  o_xstall       // Delay cycle taken
);
	vpd_pkg::vpd_state_e state_r;
	logic [31:0]         pc_r;
	logic [255:0]        pkt_r;
	logic [3:0]          slot_r;
	logic [3:0]          carry_n_r;
	logic [3:0]          g_pkt_n;
	logic [3:0]          idx;
	logic [2:0]          start_r;
	logic [31:0]         carry_r [8];
	logic [31:0]         grp     [8];
	logic [7:0]          gv;
	logic                g_open;
	logic                chain;
	logic                ready;
	logic                stall;
	logic                issue;
	logic                xstall_r;
	logic [7:0]          xhaz;
	logic [7:0]          act;
	logic [7:0]          br_v;
	logic [31:0]         br_t    [8];
	logic [31:0]         br_tgt;
	logic [7:0]          pred;
	logic [63:0]         wr_mask;
	logic [5:0]          raddr   [16];
	logic [63:0]         rdata   [16];
	logic                we      [8];
	logic                wide    [8];
	logic [5:0]          waddr   [8];
	logic [63:0]         wdata   [8];

	// --------------------------------------------------------------
	// Packed add and subtract in 32, dual 16 or quad 8 bit lanes
	// --------------------------------------------------------------
	function automatic logic [31:0] alu_op(input logic [3:0] f, input logic [1:0] w,
		input logic [31:0] a, input logic [31:0] b);
		logic [31:0] r;
		logic [8:0]  s;
		logic        c;
		logic        sub;
		r = '0;
		sub = (f == `VPD_OP_SUB);
		c = sub;
		case (f)
			`VPD_OP_ADD, `VPD_OP_SUB: begin
				for (int k = 0; k < 4; k++) begin
					s = {1'b0, a[8*k +: 8]} + {1'b0, sub ? ~b[8*k +: 8] : b[8*k +: 8]} + {8'h00, c};
					r[8*k +: 8] = s[7:0];
					// Lane edge restarts the carry chain
					c = ((w == `VPD_W8) || (w == `VPD_W16 && k == 1)) ? sub : s[8];
				end
			end
			`VPD_OP_AND:  r = a & b;
			`VPD_OP_OR:   r = a | b;
			`VPD_OP_XOR:  r = a ^ b;
			`VPD_OP_SHL:  r = b << a[4:0];
			`VPD_OP_SHR:  r = $signed(b) >>> a[4:0];
			`VPD_OP_SHRU: r = b >> a[4:0];
			default:      r = '0;
		endcase
		return r;
	endfunction

	// --------------------------------------------------------------
	// Register files
	// --------------------------------------------------------------
	vpd_regfile u_regfile (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_raddr   (raddr),
		.o_rdata   (rdata),
		.i_we      (we),
		.i_wide    (wide),
		.i_waddr   (waddr),
		.i_wdata   (wdata),
		.o_wr_mask (wr_mask),
		.o_pred    (pred)
	);

	// --------------------------------------------------------------
	// Execute group formation
	// --------------------------------------------------------------
	// Carried slots first, then packet slots while the chain holds
	always_comb begin
		chain = 1'b1;
		g_pkt_n = 4'h0;
		gv = '0;
		g_open = 1'b0;
		idx = 4'h0;
		for (int j = 0; j < 8; j++) begin
			grp[j] = '0;
			if (chain) begin
				if (4'(j) < carry_n_r) begin
					grp[j] = carry_r[j];
					gv[j] = 1'b1;
				end else begin
					idx = 4'(slot_r + 4'(j) - carry_n_r);
					if (idx < `VPD_PKT_END) begin
						grp[j] = pkt_r[{idx[2:0], 5'h00} +: 32];
						gv[j] = 1'b1;
						g_pkt_n = 4'(g_pkt_n + 4'h1);
					end else begin
						g_open = 1'b1;
					end
				end
				chain = gv[j] & grp[j][`VPD_F_P];
			end
		end
	end

	// Group complete, delay check and issue
	assign ready = (state_r == vpd_pkg::ST_RUN) & ~g_open;
	assign stall = ready & (|xhaz) & ~xstall_r;
	assign issue = ready & ~stall;

	// Lowest taken branch wins
	always_comb begin
		br_tgt = '0;
		for (int u = 7; u >= 0; u--) begin
			if (br_v[u]) br_tgt = br_t[u];
		end
	end

	// --------------------------------------------------------------
	// Functional units, four a side
	// --------------------------------------------------------------
	for (genvar u = 0; u < 8; u++) begin : g_unit
		localparam logic SIDE = (u >= 4);
		localparam int   KIND = u % 4;
		logic [31:0] ins;
		logic        hit;
		logic        cond;

		// Pick the group member whose unit field selects this unit
		always_comb begin
			ins = '0;
			hit = 1'b0;
			for (int j = 0; j < 8; j++) begin
				if (gv[j] && grp[j][`VPD_F_UNIT] == 3'(u)) begin
					ins = grp[j];
					hit = 1'b1;
				end
			end
		end

		// Predicate test
		assign cond = (ins[`VPD_F_CREG] == `VPD_CREG_ALWAYS) |
			((ins[`VPD_F_CREG] != `VPD_CREG_NEVER) &
			(pred[ins[`VPD_F_CREG]] ^ ins[`VPD_F_Z]));
		assign act[u] = issue & hit & cond;

		if (KIND == 3) begin : g_addr
			localparam int DI = u / 4;
			logic        lng;
			logic [31:0] ofs;
			logic [31:0] lin;
			logic [31:0] addr;
			logic        req_r;
			logic        st_r;
			logic [1:0]  sz_r;
			logic [31:0] addr_r;
			logic [63:0] wd_r;
			logic        ld_r;
			logic        uns_r;
			logic [5:0]  dst_r;
			logic [63:0] ld;

			// Base on own side, scaled offset, optional circular wrap
			assign lng = ins[`VPD_F_LONG];
			assign raddr[2*u] = {SIDE, lng ? `VPD_LONG_BASE : ins[`VPD_F_SRC2]};
			assign ofs = (lng ? {17'h0, ins[`VPD_F_OFS15]}
				: {27'h0, ins[`VPD_F_SRC1]}) << ins[`VPD_F_SIZE];
			assign lin = 32'(rdata[2*u][31:0] + ofs);
			assign addr = (~lng & ins[`VPD_F_CIRC])
				? {rdata[2*u][31:`VPD_CIRC_LOG2], lin[`VPD_CIRC_LOG2-1:0]}
				: lin;
			// Data register may sit on the other side
			assign raddr[2*u+1] = {lng ? SIDE : SIDE ^ ins[`VPD_F_X], ins[`VPD_F_DST]};
			assign xhaz[u] = 1'b0;
			assign br_v[u] = 1'b0;
			assign br_t[u] = '0;

			// Memory request, one cycle wide
			always_ff @(posedge i_mclk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					req_r <= 1'b0;
					st_r <= 1'b0;
					sz_r <= 2'h0;
					addr_r <= '0;
					wd_r <= '0;
					ld_r <= 1'b0;
					uns_r <= 1'b0;
					dst_r <= '0;
				end else begin
					req_r <= act[u];
					ld_r <= act[u] & ~ins[`VPD_F_ST];
					if (act[u]) begin
						st_r <= ins[`VPD_F_ST];
						sz_r <= ins[`VPD_F_SIZE];
						addr_r <= addr;
						wd_r <= rdata[2*u+1];
						uns_r <= ~lng & ins[`VPD_F_UNS];
						dst_r <= raddr[2*u+1];
					end
				end
			end

			// Load return, extended to the access size
			always_comb begin
				case (sz_r)
					`VPD_SZ_B: ld = {{56{~uns_r & i_dmem_rdata[DI][7]}}, i_dmem_rdata[DI][7:0]};
					`VPD_SZ_H: ld = {{48{~uns_r & i_dmem_rdata[DI][15]}}, i_dmem_rdata[DI][15:0]};
					`VPD_SZ_D: ld = i_dmem_rdata[DI];
					default:   ld = {32'h0, i_dmem_rdata[DI][31:0]};
				endcase
			end

			assign we[u] = ld_r;
			assign wide[u] = (sz_r == `VPD_SZ_D);
			assign waddr[u] = dst_r;
			assign wdata[u] = ld;
			assign o_dmem_req[DI] = req_r;
			assign o_dmem_we[DI] = st_r;
			assign o_dmem_size[DI] = sz_r;
			assign o_dmem_addr[DI] = addr_r;
			assign o_dmem_wdata[DI] = wd_r;
		end else begin : g_exec
			// Second source may come over the cross bus
			assign raddr[2*u] = {SIDE ^ ins[`VPD_F_X], ins[`VPD_F_SRC2]};
			assign raddr[2*u+1] = {SIDE, ins[`VPD_F_SRC1]};
			assign xhaz[u] = hit & ins[`VPD_F_X] & wr_mask[raddr[2*u]];
			assign waddr[u] = {SIDE, ins[`VPD_F_DST]};

			if (KIND == 2) begin : g_mul
				logic [63:0] mres;
				logic        mwide;
				vpd_mul_unit u_mul (
					.i_func (ins[`VPD_F_FUNC]),
					.i_a    (rdata[2*u+1][31:0]),
					.i_b    (rdata[2*u][31:0]),
					.o_res  (mres),
					.o_wide (mwide)
				);
				assign we[u] = act[u];
				assign wide[u] = mwide;
				assign wdata[u] = mres;
				assign br_v[u] = 1'b0;
				assign br_t[u] = '0;
			end else begin : g_alu
				logic isbr;
				assign isbr = (KIND == 1) && (ins[`VPD_F_FUNC] == `VPD_OP_BR);
				assign we[u] = act[u] & ~isbr;
				assign wide[u] = 1'b0;
				assign wdata[u] = {32'h0, alu_op(ins[`VPD_F_FUNC], ins[`VPD_F_SIMD],
					rdata[2*u+1][31:0], rdata[2*u][31:0])};
				assign br_v[u] = act[u] & isbr;
				assign br_t[u] = rdata[2*u][31:0];
			end
		end
	end

	// --------------------------------------------------------------
	// Fetch and dispatch sequencing
	// --------------------------------------------------------------
	// Packet position, fetch address and carried count
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= vpd_pkg::ST_FETCH;
			pc_r <= `VPD_RESET_PC;
			slot_r <= 4'h0;
			start_r <= 3'h0;
			carry_n_r <= 4'h0;
		end else begin
			case (state_r)
				vpd_pkg::ST_FETCH: begin
					if (i_fetch_valid) begin
						state_r <= vpd_pkg::ST_RUN;
						slot_r <= {1'b0, start_r};
					end
				end
				vpd_pkg::ST_RUN: begin
					if (issue && (|br_v)) begin
						pc_r <= {br_tgt[31:5], 5'h00};
						start_r <= br_tgt[4:2];
						carry_n_r <= 4'h0;
						state_r <= vpd_pkg::ST_FETCH;
					end else if (issue) begin
						carry_n_r <= 4'h0;
						slot_r <= 4'(slot_r + g_pkt_n);
						if (4'(slot_r + g_pkt_n) == `VPD_PKT_END) begin
							pc_r <= 32'(pc_r + `VPD_PKT_BYTES);
							start_r <= 3'h0;
							state_r <= vpd_pkg::ST_FETCH;
						end
					end else if (g_open) begin
						carry_n_r <= 4'(carry_n_r + g_pkt_n);
						pc_r <= 32'(pc_r + `VPD_PKT_BYTES);
						start_r <= 3'h0;
						state_r <= vpd_pkg::ST_FETCH;
					end
				end
				default: state_r <= vpd_pkg::ST_FETCH;
			endcase
		end
	end

	// Fetched packet
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) pkt_r <= '0;
		else if (state_r == vpd_pkg::ST_FETCH && i_fetch_valid) pkt_r <= i_fetch_data;
	end

	// Head of a group that runs past the packet end
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int j = 0; j < 8; j++) carry_r[j] <= '0;
		end else if (state_r == vpd_pkg::ST_RUN && g_open) begin
			for (int j = 0; j < 8; j++) carry_r[j] <= grp[j];
		end
	end

	// Issue record and single delay cycle
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			xstall_r <= 1'b0;
			o_issue_mask <= '0;
		end else begin
			xstall_r <= stall;
			o_issue_mask <= act;
		end
	end

	assign o_xstall = xstall_r;
	assign o_fetch_req = (state_r == vpd_pkg::ST_FETCH);
	assign o_fetch_addr = pc_r;
endmodule

// File: verif/vpd_dispatch_core_properties.sv
// Port checks of the packet dispatch core
`timescale 1ns/1ps
module vpd_dispatch_core_checker (
	input wire logic        i_mclk,        // Core clock
	input wire logic        i_reset_n,     // Reset, low
	input wire logic        o_fetch_req,   // Packet wanted
	input wire logic [31:0] o_fetch_addr,  // Packet address
	input wire logic        i_fetch_valid, // Packet present
	input wire logic [1:0]  o_dmem_req,    // Data access
	input wire logic [7:0]  o_issue_mask,  // Units issued
	input wire logic        o_xstall       // Delay cycle
);
	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	// ----------------------------------------
	// Fetch port
	// ----------------------------------------
	property p_reset_start;
		!$past(i_reset_n) |-> o_fetch_req && o_fetch_addr == 32'h0000_0000;
	endproperty
	a_reset_start: assert property (p_reset_start)
		else $error("fetch does not start at zero");
	property p_fetch_align;
		o_fetch_req |-> o_fetch_addr[4:0] == 5'h00;
	endproperty
	a_fetch_align: assert property (p_fetch_align)
		else $error("packet address not on a packet boundary");
	property p_fetch_drop;
		o_fetch_req && i_fetch_valid |=> !o_fetch_req;
	endproperty
	a_fetch_drop: assert property (p_fetch_drop)
		else $error("new fetch before packet dispatched");
	property p_fetch_hold;
		o_fetch_req && !i_fetch_valid |=> o_fetch_req;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold)
		else $error("fetch request withdrawn");
	property p_addr_stable;
		o_fetch_req && !i_fetch_valid |=> $stable(o_fetch_addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable)
		else $error("fetch address moved while waiting");
	// ----------------------------------------
	// Dispatch and data port
	// ----------------------------------------
	property p_xstall_pulse;
		o_xstall |=> !o_xstall;
	endproperty
	a_xstall_pulse: assert property (p_xstall_pulse)
		else $error("delay longer than one cycle");
	property p_dmem_a;
		o_dmem_req[0] |-> o_issue_mask[3];
	endproperty
	a_dmem_a: assert property (p_dmem_a)
		else $error("side a access without address unit");
	property p_dmem_b;
		!o_issue_mask[7] |-> !o_dmem_req[1];
	endproperty
	a_dmem_b: assert property (p_dmem_b)
		else $error("side b access without address unit");
endmodule
bind vpd_dispatch_core vpd_dispatch_core_checker vpd_dispatch_core_checker_inst (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .o_fetch_req(o_fetch_req),
	.o_fetch_addr(o_fetch_addr), .i_fetch_valid(i_fetch_valid),
	.o_dmem_req(o_dmem_req), .o_issue_mask(o_issue_mask), .o_xstall(o_xstall)
);

// File: verif/vpd_mem_model.sv
// Program and data memory facing the dispatch core
`timescale 1ns/1ps
module vpd_mem_model (
	input  wire logic             i_mclk,        // Core clock
	input  wire logic             i_reset_n,     // Reset, low
	input  wire logic             i_fetch_req,   // Packet wanted
	input  wire logic [31:0]      i_fetch_addr,  // Packet address
	output logic                  o_fetch_valid, // Packet present
	output logic [255:0]          o_fetch_data,  // Packet
	input  wire logic [1:0]       i_dmem_req,    // Access per side
	input  wire logic [1:0][31:0] i_dmem_addr,   // Byte address
	output logic [1:0][63:0]      o_dmem_rdata   // Load data
);
	logic [255:0] prog [4];
	logic         slow_r = 1'b0;
	logic         wait_r = 1'b0;
	logic [63:0]  junk_r = 64'h5A5A_C3C3_0FF0_9669;
	initial o_fetch_valid = 1'b0;
	initial o_fetch_data = '0;
	// Packets answered alternately at once and one cycle late
	always @(posedge i_mclk) begin
		#1;
		junk_r = ~junk_r;
		if (!i_reset_n || o_fetch_valid) begin
			o_fetch_valid = 1'b0;
			o_fetch_data = ~o_fetch_data;
		end else if (i_fetch_req && slow_r && !wait_r) begin
			wait_r = 1'b1;
		end else if (i_fetch_req) begin
			o_fetch_valid = 1'b1;
			o_fetch_data = (i_fetch_addr < 32'h80) ? prog[i_fetch_addr[6:5]] : {8{32'hE000_0000}};
			slow_r = ~slow_r;
			wait_r = 1'b0;
		end
	end
	// Load data in the request cycle, changing junk otherwise
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			o_dmem_rdata[s] = i_dmem_req[s] ?
				{32'hA5A5_0000 ^ i_dmem_addr[s], i_dmem_addr[s] + 32'h11} : junk_r;
		end
	end
endmodule

// File: verif/vpd_dispatch_core_bench.sv
// Self-checking bench of the packet dispatch core
`timescale 1ns/1ps
module vpd_dispatch_core_bench;
	logic             i_mclk = 1'b0;
	logic             i_reset_n = 1'b0;
	logic             o_fetch_req;
	logic [31:0]      o_fetch_addr;
	logic             i_fetch_valid;
	logic [255:0]     i_fetch_data;
	logic [1:0]       o_dmem_req;
	logic [1:0]       o_dmem_we;
	logic [1:0][1:0]  o_dmem_size;
	logic [1:0][31:0] o_dmem_addr;
	logic [1:0][63:0] o_dmem_wdata;
	logic [1:0][63:0] i_dmem_rdata;
	logic [7:0]       o_issue_mask;
	logic             o_xstall;
	int               fails = 0;
	int               check_count = 0;
	int               xs_n = 0;
	logic [63:0]      mq [$];
	logic [63:0]      dq [$];
	localparam logic [31:0] NV = 32'hE000_0000;
	vpd_dispatch_core vpd_dispatch_core_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr),
		.i_fetch_valid(i_fetch_valid), .i_fetch_data(i_fetch_data),
		.o_dmem_req(o_dmem_req), .o_dmem_we(o_dmem_we), .o_dmem_size(o_dmem_size),
		.o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata),
		.i_dmem_rdata(i_dmem_rdata), .o_issue_mask(o_issue_mask), .o_xstall(o_xstall));
	vpd_mem_model vpd_mem_model_inst (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_fetch_req(o_fetch_req), .i_fetch_addr(o_fetch_addr),
		.o_fetch_valid(i_fetch_valid), .o_fetch_data(i_fetch_data),
		.i_dmem_req(o_dmem_req), .i_dmem_addr(o_dmem_addr), .o_dmem_rdata(i_dmem_rdata));
	always #5 i_mclk = ~i_mclk;
	// Trace of issued groups, delay cycles and data accesses
	always @(posedge i_mclk) begin
		if (i_reset_n) begin
			if (o_issue_mask != 8'h00) mq.push_back({56'h0, o_issue_mask});
			if (o_xstall) xs_n++;
			for (int s = 0; s < 2; s++) begin
				if (o_dmem_req[s]) begin
					dq.push_back({28'h0, s[0], o_dmem_we[s], o_dmem_size[s], o_dmem_addr[s]});
					if (o_dmem_we[s]) dq.push_back(o_dmem_size[s] == 2'h3 ?
						o_dmem_wdata[s] : {32'h0, o_dmem_wdata[s][31:0]});
				end
			end
		end
	end
	// Instruction word from its fields
	function automatic logic [31:0] ins(input logic [31:0] c, z, d, s2, s1, x, f, m, u, p);
		ins = {c[2:0], z[0], d[4:0], s2[4:0], s1[4:0], x[0], f[3:0], m[3:0], u[2:0], p[0]};
	endfunction
	function automatic logic [31:0] op(input logic [31:0] u, p);
		op = ins(0, 0, 1, 0, 0, 0, 0, 0, u, p);
	endfunction
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic chk_q(input string name, input logic [63:0] got [$], exp [$]);
		chk(name, 64'(got.size()), 64'(exp.size()));
		foreach (exp[i]) chk(name, (i < got.size()) ? got[i] : 64'hX, exp[i]);
	endtask
	// Loads two packets, resets the core and lets it run
	task automatic run(input logic [255:0] p0, p1);
		@(posedge i_mclk);
		#1;
		i_reset_n = 1'b0;
		vpd_mem_model_inst.prog[0] = p0;
		vpd_mem_model_inst.prog[1] = p1;
		vpd_mem_model_inst.prog[2] = {8{NV}};
		vpd_mem_model_inst.prog[3] = {8{NV}};
		repeat (4) @(posedge i_mclk);
		#1;
		mq.delete();
		dq.delete();
		xs_n = 0;
		i_reset_n = 1'b1;
		repeat (40) @(posedge i_mclk);
		#1;
	endtask
	// Three groups, the last one spanning into the next packet
	task automatic t_groups;
		run({op(3, 1), op(7, 1), op(6, 1), op(5, 1), op(4, 0), op(2, 0), op(1, 1), op(0, 1)},
			{{7{NV}}, op(0, 0)});
		chk_q("groups", mq, '{64'h07, 64'h10, 64'hE9});
	endtask
	// Cross read of a fresh register, then same-side reads and predicates
	task automatic t_cross;
		run({{3{NV}}, ins(1, 1, 6, 0, 0, 0, 0, 0, 6, 0), ins(1, 0, 5, 0, 0, 0, 0, 0, 5, 0),
			ins(0, 0, 3, 2, 2, 0, 0, 0, 1, 0), ins(0, 0, 2, 1, 0, 1, 0, 0, 0, 0), op(4, 0)},
			{8{NV}});
		chk_q("order", mq, '{64'h10, 64'h01, 64'h02, 64'h40});
		chk("delays", 64'(xs_n), 64'h1);
	endtask
	// Doubleword load, unaligned and cross-side stores
	task automatic t_mem;
		run({NV, NV, ins(0, 0, 4, 0, 2, 1, 0, 6, 7, 0), ins(0, 0, 4, 4, 0, 0, 0, 7, 3, 0),
			ins(0, 0, 4, 4, 1, 0, 0, 6, 3, 0), NV, NV, ins(0, 0, 4, 0, 1, 0, 0, 3, 3, 0)},
			{8{NV}});
		chk_q("data", dq, '{64'h0000_0003_0000_0008,
			64'h0000_0006_0000_001D, 64'h19, 64'h0000_0007_0000_0019,
			64'hA5A5_0008_0000_0019, 64'h0000_000E_0000_0008, 64'h19});
	endtask
	// Signed long load, circular store, packed math and a taken branch
	task automatic t_calc;
		logic [31:0] sb;
		sb = ins(0, 0, 6, 0, 1, 0, 0, 6, 3, 0);
		run({sb, ins(0, 0, 0, 3, 0, 0, 8, 0, 1, 0), ins(0, 0, 4, 0, 0, 0, 0, 7, 3, 0),
			ins(0, 0, 6, 4, 5, 0, 1, 4, 0, 0), ins(0, 0, 4, 2, 2, 0, 0, 0, 2, 0),
			ins(0, 0, 2, 2, 8, 0, 8, 6, 3, 0), ins(0, 0, 3, 0, 0, 1, 7, 8, 3, 0),
			ins(0, 0, 2, 0, 30, 1, 15, 8, 3, 0)},
			{{3{NV}}, ins(0, 0, 7, 0, 4, 0, 0, 6, 3, 0), ins(0, 0, 6, 0, 3, 0, 0, 6, 3, 0),
			ins(0, 0, 7, 2, 0, 0, 6, 0, 2, 0), sb, sb});
		chk_q("calc", dq, '{64'h3DF, 64'h17,
			64'h0000_0006_FFFF_FC10, 64'hFFFF_FFF0, 64'h0000_0007_0000_0000,
			64'h0000_0001_0000_0100, 64'h0000_0006_0000_000C, 64'h0000_FF01,
			64'h0000_0006_0000_0010, 64'h0808_0804});
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#60000;
		fails++;
		end_of_test;
	end
	initial begin
		t_groups;
		t_cross;
		t_mem;
		t_calc;
		end_of_test;
	end
endmodule
